// ==== logic/frame_stats_pkg.sv ====
// Purpose: shared constants and carriers for the frame statistics block
// Assumes: 18 x 18 array, six-bit pixels, one byte per register
// Notes:   offsets are the register addresses of the serial port
package frame_stats_pkg;

    // ----------------------------------------------------------------
    // register addresses
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_CONFIG = 8'h00;
    localparam logic [7:0] ADDR_PEAK   = 8'h05;
    localparam logic [7:0] ADDR_FLOOR  = 8'h06;
    localparam logic [7:0] ADDR_TOTAL  = 8'h07;
    localparam logic [7:0] ADDR_DUMP   = 8'h08;

    // ----------------------------------------------------------------
    // fields and sizes
    // ----------------------------------------------------------------
    localparam int          STAY_AWAKE_POS = 0;
    localparam int          SUM_SHIFT      = 7;
    localparam int          SUM_W          = 15;
    localparam int          LEVEL_W        = 6;
    localparam int          IDX_W          = 9;
    localparam logic [8:0]  COL_LEN        = 9'h012;
    localparam logic [8:0]  PIX_COUNT      = 9'h144;
    localparam logic [8:0]  PIX_FIRST      = 9'h001;
    localparam logic [5:0]  LEVEL_BLACK    = 6'h00;
    localparam logic [5:0]  LEVEL_WHITE    = 6'h3f;
    localparam logic [10:0] SLEEP_FRAMES   = 11'h5dc;
    localparam logic [7:0]  READ_RESET     = 8'h00;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic               strobe;
        logic               first;
        logic [LEVEL_W-1:0] level;
    } pix_beat_t;

    typedef struct packed {
        logic               clk;
        logic               first;
        logic [LEVEL_W-1:0] level;
    } link_pins_t;

endpackage

// ==== logic/pixel_link_rx.sv ====
// Purpose: brings the pixel link into the core clock and finds its edges
// Assumes: link clock far slower than clk, data steady around its rise
// Notes:   one strobe per rising link edge
`timescale 1ns/1ps
module pixel_link_rx
    import frame_stats_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire link_pins_t link_in,
    output pix_beat_t       beat
);

    typedef struct packed {
        link_pins_t meta;
        link_pins_t sync;
        logic       clk_seen;
        pix_beat_t  beat;
    } rx_state_t;

    rx_state_t st_reg;
    rx_state_t st_next;

    // ----------------------------------------------------------------
    // two stages, edge taken from the second stage only
    // ----------------------------------------------------------------
    always_comb begin
        st_next             = st_reg;
        st_next.meta        = link_in;
        st_next.sync        = st_reg.meta;
        st_next.clk_seen    = st_reg.sync.clk;
        st_next.beat.strobe = st_reg.sync.clk & ~st_reg.clk_seen;
        st_next.beat.first  = st_reg.sync.first;
        st_next.beat.level  = st_reg.sync.level;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign beat = st_reg.beat;

endmodule

// ==== logic/frame_stats_pixel_dump.sv ====
// Purpose: per-frame peak, floor and total plus a one-pixel grabber
// Assumes: register strobes come from the serial port on clk
// Notes:   read data appears the cycle after the read strobe
`timescale 1ns/1ps
// Function
// - peak register gives frame maximum in bits 5..0, top bits zero
// - floor register gives frame minimum in bits 5..0, top bits zero
// - peak and floor are refreshed at every frame end
// - all 324 pixels of a frame sum into fifteen bits
// - total register returns the sum shifted right by seven
// - any dump write rewinds grabber to pixel one with frame-first flag
// - each dump read of a held valid pixel moves the pixel index on by one
// - after pixel 324 the index wraps to one, flag set again
// - grabber takes at most one pixel per frame
// - every dump write, and every dump read unless grabber is live that cycle, arms grabber for the next frame
// - a latched pixel is held until a dump read or a dump write
// - dump word: flag bit 7, valid bit 6, level bits 5..0
// - valid flag only while a fresh pixel is held
// - indices run column by column, 18 per column, up to 324
// - stay-awake bit holds awake, else sleep after 1500 idle frames
// - level zero is black, 63 is white
module frame_stats_pixel_dump
    import frame_stats_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               srst,
    input  wire reg_req_t           reg_req,
    output logic [7:0]              rd_data,
    input  wire logic               pix_link_clk,
    input  wire logic               pix_link_first,
    input  wire logic [LEVEL_W-1:0] pix_link_level,
    input  wire logic               motion_seen,
    output logic                    awake
);

    typedef struct packed {
        logic [IDX_W-1:0]   pos;
        logic [LEVEL_W-1:0] run_max;
        logic [LEVEL_W-1:0] run_min;
        logic [SUM_W-1:0]   run_sum;
        logic [LEVEL_W-1:0] peak;
        logic [LEVEL_W-1:0] floor;
        logic [SUM_W-1:0]   total;
        logic [IDX_W-1:0]   grab_idx;
        logic               grab_wait;
        logic               grab_live;
        logic               grab_valid;
        logic [LEVEL_W-1:0] grab_level;
        logic               stay;
        logic [10:0]        idle_frames;
        logic               awake;
        logic [7:0]         rdata;
    } core_state_t;

    core_state_t st_reg;
    core_state_t st_next;
    pix_beat_t   beat;
    link_pins_t  link_in;

    logic [IDX_W-1:0]   n_pos;
    logic [LEVEL_W-1:0] n_max;
    logic [LEVEL_W-1:0] n_min;
    logic [SUM_W-1:0]   n_sum;
    logic               frame_end;
    logic               live_now;
    logic               dump_rd;
    logic               dump_wr;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // one step along the index, shared by stream count and grabber
    function automatic logic [IDX_W-1:0] step_index(input logic [IDX_W-1:0] idx);
        return idx + PIX_FIRST;
    endfunction

    function automatic logic addr_is(input reg_req_t req, input logic [7:0] addr);
        return req.addr == addr;
    endfunction

    // levels compare unsigned, so zero is always the darkest
    function automatic logic [LEVEL_W-1:0] pick_level(input logic [LEVEL_W-1:0] a,
                                                      input logic [LEVEL_W-1:0] b,
                                                      input logic               larger);
        logic take_a;
        take_a = larger ? (a > b) : (a < b);
        return take_a ? a : b;
    endfunction

    // ----------------------------------------------------------------
    // pixel link intake
    // ----------------------------------------------------------------
    assign link_in = '{clk: pix_link_clk, first: pix_link_first, level: pix_link_level};

    pixel_link_rx u_rx (
        .clk     (clk),
        .srst    (srst),
        .link_in (link_in),
        .beat    (beat)
    );

    assign dump_rd = reg_req.rd & addr_is(reg_req, ADDR_DUMP);
    assign dump_wr = reg_req.wr & addr_is(reg_req, ADDR_DUMP);

    // ----------------------------------------------------------------
    // running frame statistics
    // ----------------------------------------------------------------
    always_comb begin
        if (beat.first) begin
            n_pos = PIX_FIRST;
            n_max = beat.level;
            n_min = beat.level;
            n_sum = SUM_W'(beat.level);
        end else begin
            n_pos = step_index(st_reg.pos);
            n_max = pick_level(beat.level, st_reg.run_max, 1'b1);
            n_min = pick_level(beat.level, st_reg.run_min, 1'b0);
            n_sum = st_reg.run_sum + SUM_W'(beat.level);
        end
        frame_end = beat.strobe & (n_pos == PIX_COUNT);
        // arming only goes live at a frame start
        live_now  = st_reg.grab_live | (st_reg.grab_wait & beat.strobe & beat.first);
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        if (beat.strobe) begin
            st_next.pos     = n_pos;
            st_next.run_max = n_max;
            st_next.run_min = n_min;
            st_next.run_sum = n_sum;
        end
        if (frame_end) begin
            st_next.peak  = n_max;
            st_next.floor = n_min;
            st_next.total = n_sum;
        end

        // grabber capture; waits a whole frame rather than risk a torn one
        if (beat.strobe & beat.first & st_reg.grab_wait) begin
            st_next.grab_wait = 1'b0;
            st_next.grab_live = 1'b1;
        end
        // valid set only by a capture
        if (beat.strobe & live_now & (n_pos == st_reg.grab_idx)) begin
            st_next.grab_level = beat.level;
            st_next.grab_valid = 1'b1;
            st_next.grab_live  = 1'b0;
            st_next.grab_wait  = 1'b0;
        end

        // register reads
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                ADDR_PEAK:   st_next.rdata = {2'b00, st_reg.peak};
                ADDR_FLOOR:  st_next.rdata = {2'b00, st_reg.floor};
                ADDR_TOTAL:  st_next.rdata = st_reg.total[SUM_W-1:SUM_SHIFT];
                ADDR_CONFIG: st_next.rdata = {7'h00, st_reg.stay};
                ADDR_DUMP:   st_next.rdata = {st_reg.grab_idx == PIX_FIRST,
                                              st_reg.grab_valid,
                                              st_reg.grab_valid ? st_reg.grab_level
                                                                : LEVEL_BLACK};
                default:     st_next.rdata = READ_RESET;
            endcase
        end

        // held until a read takes it or a dump write clears it
        if (dump_rd & st_reg.grab_valid) begin
            if (st_reg.grab_idx == PIX_COUNT) begin
                st_next.grab_idx = PIX_FIRST;
            end else begin
                st_next.grab_idx = step_index(st_reg.grab_idx);
            end
            st_next.grab_valid = 1'b0;
            st_next.grab_wait  = 1'b1;
            st_next.grab_live  = 1'b0;
        end else if (dump_rd & ~live_now & ~st_next.grab_valid) begin
            // invalid read leaves index alone, only arms
            st_next.grab_wait = 1'b1;
        end
        if (dump_wr) begin
            st_next.grab_idx   = PIX_FIRST;
            st_next.grab_valid = 1'b0;
            st_next.grab_wait  = 1'b1;
            st_next.grab_live  = 1'b0;
        end

        if (reg_req.wr & addr_is(reg_req, ADDR_CONFIG)) begin
            st_next.stay = reg_req.wdata[STAY_AWAKE_POS];
        end

        // awake control
        // motion or stay wins over the idle count
        if (st_reg.stay | motion_seen) begin
            st_next.awake       = 1'b1;
            st_next.idle_frames = '0;
        end else if (frame_end & st_reg.awake) begin
            if (st_reg.idle_frames == SLEEP_FRAMES - 11'h001) begin
                st_next.awake = 1'b0;
            end else begin
                st_next.idle_frames = st_reg.idle_frames + 11'h001;
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            st_reg          <= '0;
            st_reg.run_min  <= LEVEL_WHITE;
            st_reg.grab_idx <= PIX_FIRST;
            st_reg.awake    <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rd_data = st_reg.rdata;
    assign awake   = st_reg.awake;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    chk_peak_read: assert property (
        reg_req.rd && reg_req.addr == ADDR_PEAK |=> rd_data == {2'b00, $past(st_reg.peak)})
        else $error("peak read wrong");

    chk_floor_read: assert property (
        reg_req.rd && reg_req.addr == ADDR_FLOOR |=> rd_data[7:6] == 2'b00
        && rd_data[5:0] == $past(st_reg.floor))
        else $error("floor read wrong");

    chk_frame_commit: assert property (
        frame_end |=> st_reg.peak == $past(n_max) && st_reg.floor == $past(n_min))
        else $error("extremes not committed");

    chk_sum_commit: assert property (
        frame_end |=> st_reg.total == $past(st_reg.run_sum) + SUM_W'($past(beat.level)))
        else $error("sum not committed");

    chk_total_shift: assert property (
        reg_req.rd && reg_req.addr == ADDR_TOTAL
        |=> rd_data == $past(st_reg.total[SUM_W-1:SUM_SHIFT]))
        else $error("total shift wrong");

    chk_write_rewind: assert property (
        dump_wr |=> st_reg.grab_idx == PIX_FIRST && !st_reg.grab_valid && st_reg.grab_wait)
        else $error("write did not rewind");

    chk_index_step: assert property (
        dump_rd && !dump_wr && st_reg.grab_valid && st_reg.grab_idx != PIX_COUNT
        |=> st_reg.grab_idx == $past(st_reg.grab_idx) + PIX_FIRST)
        else $error("index did not advance");

    chk_index_wrap: assert property (
        dump_rd && st_reg.grab_valid && st_reg.grab_idx == PIX_COUNT
        |=> st_reg.grab_idx == PIX_FIRST ##0 st_reg.grab_wait)
        else $error("index did not wrap");

    chk_invalid_read: assert property (
        dump_rd && !dump_wr && !st_reg.grab_valid |=> $stable(st_reg.grab_idx))
        else $error("invalid read moved index");

    chk_dump_word: assert property (
        dump_rd |=> rd_data[6] == $past(st_reg.grab_valid)
        && rd_data[7] == ($past(st_reg.grab_idx) == PIX_FIRST))
        else $error("dump word layout wrong");

    chk_hold_pixel: assert property (
        st_reg.grab_valid && !dump_rd && !dump_wr
        |=> st_reg.grab_valid && $stable(st_reg.grab_level))
        else $error("held pixel changed");

    chk_one_per_frame: assert property (
        $rose(st_reg.grab_valid) |-> !st_reg.grab_live && !st_reg.grab_wait)
        else $error("grabber still armed after capture");

    chk_stay_awake: assert property (
        st_reg.stay |=> awake)
        else $error("sleep despite stay-awake");

    chk_config_read: assert property (
        reg_req.rd && reg_req.addr == ADDR_CONFIG
        |=> rd_data == {7'h00, $past(st_reg.stay)})
        else $error("config read wrong");

    chk_motion_wake: assert property (
        motion_seen |=> awake)
        else $error("asleep despite motion");

    chk_sleep_count: assert property (
        $fell(awake) |-> !$past(st_reg.stay) && !$past(motion_seen)
        && $past(st_reg.idle_frames) == SLEEP_FRAMES - 11'h001)
        else $error("slept before idle count ran out");

    chk_floor_below_peak: assert property (
        st_reg.floor <= st_reg.peak)
        else $error("floor above peak");

    chk_read_arms: assert property (
        dump_rd && !st_reg.grab_live && !st_reg.grab_wait |=> st_reg.grab_wait)
        else $error("dump read did not arm");

    chk_capture_index: assert property (
        $rose(st_reg.grab_valid) |-> st_reg.pos == st_reg.grab_idx)
        else $error("captured pixel at wrong index");

    chk_capture_level: assert property (
        $rose(st_reg.grab_valid) |-> st_reg.grab_level == $past(beat.level))
        else $error("captured level wrong");

    chk_live_at_first: assert property (
        $rose(st_reg.grab_live) |-> $past(beat.strobe) && $past(beat.first))
        else $error("grabber went live mid-frame");

    cov_capture: cover property ($rose(st_reg.grab_valid));
    cov_wrap:    cover property (dump_rd && st_reg.grab_valid && st_reg.grab_idx == PIX_COUNT);
    cov_sleep:   cover property ($fell(awake));
    cov_commit:  cover property (frame_end);
    cov_rewind:  cover property (dump_wr);

endmodule

// ==== bench/pixel_frame_source.sv ====
// Purpose: pixel array stand-in that plays whole frames onto the pixel link
// Assumes: link period 320 ns, data changes while the link clock is low
// Notes:   link clock stands still between frames; released lines show inverse
`timescale 1ns/1ps
module pixel_frame_source
    import frame_stats_pkg::*;
(
    output logic               link_clk,
    output logic               link_first,
    output logic [LEVEL_W-1:0] link_level
);

    // ----------------------------------------------------------------
    // idle lines
    // ----------------------------------------------------------------
    initial begin
        link_clk   = 1'b0;
        link_first = 1'b0;
        link_level = 6'h15;
    end

    // ----------------------------------------------------------------
    // frame content
    // ----------------------------------------------------------------
    // levels 0 black, 63 white
    function automatic logic [LEVEL_W-1:0] pix_level(input int mode, input int f, input int i);
        case (mode)
            1: return LEVEL_WHITE;
            2: return LEVEL_BLACK;
            default: return 6'((i * 7 + f * 13) % 64);
        endcase
    endfunction

    // indices sent one to 324, column order
    task automatic send_frame(input int mode, input int f);
        for (int i = 1; i <= int'(PIX_COUNT); i++) begin
            link_first = (i == 1);
            link_level = pix_level(mode, f, i);
            #160 link_clk = 1'b1;
            #160 link_clk = 1'b0;
        end
        // clock parked, so the inverted lines are never sampled
        link_first = ~link_first;
        link_level = ~link_level;
    endtask

endmodule

// ==== bench/frame_stats_pixel_dump_tb.sv ====
// Purpose: register-level checks of frame statistics and pixel grabber
// Assumes: read answer taken one cycle after the read strobe
// Notes:   full 324-frame image dump is out of reach of the run length
`timescale 1ns/1ps
`define CHECK(got, exp) begin num_checks++; if ((got) !== (exp)) begin num_errors++; \
    $display("[FAIL] %0t got %h expected %h", $time, (got), (exp)); end end
module frame_stats_pixel_dump_tb
    import frame_stats_pkg::*;
;
    logic               clk;
    logic               srst;
    reg_req_t           req;
    logic [7:0]         rd_data;
    logic               lclk;
    logic               lfirst;
    logic [LEVEL_W-1:0] llevel;
    logic               motion_seen;
    logic               awake;
    logic [7:0]         got;
    int                 num_errors;
    int                 num_checks;

    // ----------------------------------------------------------------
    // clock, design and pixel source
    // ----------------------------------------------------------------
    initial clk = 1'b0;
    always #20 clk = ~clk;

    frame_stats_pixel_dump i_dut (
        .clk            (clk),
        .srst           (srst),
        .reg_req        (req),
        .rd_data        (rd_data),
        .pix_link_clk   (lclk),
        .pix_link_first (lfirst),
        .pix_link_level (llevel),
        .motion_seen    (motion_seen),
        .awake          (awake)
    );

    pixel_frame_source i_src (
        .link_clk   (lclk),
        .link_first (lfirst),
        .link_level (llevel)
    );

    // ----------------------------------------------------------------
    // register access
    // ----------------------------------------------------------------
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        req.rd   = 1'b1;
        req.addr = a;
        @(posedge clk);
        #1 req.rd = 1'b0;
        @(posedge clk);
        #1 d = rd_data;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        req.wr    = 1'b1;
        req.addr  = a;
        req.wdata = d;
        @(posedge clk);
        #1 req.wr = 1'b0;
    endtask

    task automatic frame(input int mode, input int f);
        i_src.send_frame(mode, f);
        // beats need a few cycles to cross before the frame commits
        repeat (12) @(posedge clk);
        #1;
    endtask

    // expected statistics worked out from the frame content
    task automatic check_stats(input int mode, input int f);
        int mx;
        int mn;
        int sm;
        int v;
        mx = 0;
        mn = 63;
        sm = 0;
        for (int i = 1; i <= 324; i++) begin
            v  = int'(i_src.pix_level(mode, f, i));
            mx = (v > mx) ? v : mx;
            mn = (v < mn) ? v : mn;
            sm += v;
        end
        rd_reg(ADDR_PEAK, got);
        `CHECK(got, {2'b00, 6'(mx)})
        rd_reg(ADDR_FLOOR, got);
        `CHECK(got, {2'b00, 6'(mn)})
        rd_reg(ADDR_TOTAL, got);
        `CHECK(got, 8'(15'(sm) >> SUM_SHIFT))
    endtask

    function automatic logic [7:0] dump_word(input logic sof, input int f, input int i);
        return {sof, 1'b1, i_src.pix_level(0, f, i)};
    endfunction

    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // watchdog: nine frames of traffic, limit about thirty frames
    // ----------------------------------------------------------------
    initial begin
        repeat (80000) @(posedge clk);
        num_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_sim();
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        num_errors  = 0;
        num_checks  = 0;
        srst        = 1'b1;
        req         = '0;
        motion_seen = 1'b0;
        got         = 8'h00;
        repeat (5) @(posedge clk);
        #1 srst = 1'b0;

        `CHECK(awake, 1'b1)
        rd_reg(ADDR_PEAK, got);
        `CHECK(got, 8'h00)
        rd_reg(ADDR_TOTAL, got);
        `CHECK(got, 8'h00)
        rd_reg(8'h01, got);
        `CHECK(got, READ_RESET)
        $display("reset values done");

        // stats over mixed, white and black frames; they must change
        wr_reg(ADDR_PEAK, 8'haa);
        frame(0, 1);
        check_stats(0, 1);
        frame(1, 2);
        check_stats(1, 2);
        rd_reg(ADDR_TOTAL, got);
        `CHECK(got, 8'h9f)
        frame(2, 3);
        check_stats(2, 3);
        $display("frame statistics done");

        // host forces awake, stay bit reads back
        wr_reg(ADDR_CONFIG, 8'h01);
        rd_reg(ADDR_CONFIG, got);
        `CHECK(got[STAY_AWAKE_POS], 1'b1)
        motion_seen = 1'b1;
        @(posedge clk);
        #1 motion_seen = 1'b0;
        `CHECK(awake, 1'b1)

        // rewind, then a read with nothing captured yet
        wr_reg(ADDR_DUMP, 8'h5a);
        rd_reg(ADDR_DUMP, got);
        `CHECK(got, 8'h80)
        frame(0, 4);
        rd_reg(ADDR_DUMP, got);
        `CHECK(got, dump_word(1'b1, 4, 1))
        rd_reg(ADDR_DUMP, got);
        `CHECK(got, 8'h00)
        frame(0, 5);
        rd_reg(ADDR_DUMP, got);
        `CHECK(got, dump_word(1'b0, 5, 2))
        // two frames pass unread: first capture is kept
        frame(0, 6);
        frame(0, 7);
        rd_reg(ADDR_DUMP, got);
        `CHECK(got, dump_word(1'b0, 6, 3))
        frame(0, 8);
        rd_reg(ADDR_DUMP, got);
        `CHECK(got, dump_word(1'b0, 8, 4))
        rd_reg(ADDR_DUMP, got);
        `CHECK(got[6], 1'b0)
        // mid-image write rewinds to pixel one
        wr_reg(ADDR_DUMP, 8'h00);
        frame(0, 9);
        rd_reg(ADDR_DUMP, got);
        `CHECK(got, dump_word(1'b1, 9, 1))
        $display("pixel grabber done");
        end_sim();
    end

endmodule
